//--- logic/raq_defines.vh
// Purpose: Constants for the radio auto-ack and I/Q state sequencer
// Assumes: 125 MHz core clock, plain Verilog-2005
// Notes: Command and state codes are local encodings
// Function
// - Freeze gain control on preamble detect
// - Raise frame-start flag on valid header
// - Raise address-match flag on filter match
// - Frame-end flag on good checksum, go prepare if no ack due
// - Bad or short frame: stay receive, release gain
// - Ack timer from delay regs, send ack
// - Ack done: tx-end flag, enter prepare
// - Present frame length and buffer start
// - Energy measurement launched at frame start
// - Chip-mode 1 selects I/Q; variant forces I/Q
// - Single/continuous energy start on mode write
// - Automatic energy starts on freeze bit set
// - Prepare raises ready; I/Q enables tx serial
// - Embedded control: stream flag starts, SPI tx and prepare ignored
// - Prepare command ends tx; ready on arrival
// - Embedded flag fall: ramp down, back to prepare
// - I/Q receive streams samples continuously
// - Prepare command leaves receive; ready raised
`ifndef RAQ_DEFINES_VH
`define RAQ_DEFINES_VH
`define RAQ_CMD_NOP 3'h0
`define RAQ_CMD_OFF 3'h2
`define RAQ_CMD_TRANSMIT_PREPARE_STATE 3'h3
`define RAQ_CMD_TX 3'h4
`define RAQ_CMD_RX 3'h5
`define RAQ_ST_OFF 3'h2
`define RAQ_ST_PREP 3'h3
`define RAQ_ST_TX 3'h4
`define RAQ_ST_RX 3'h5
`define RAQ_ST_ACKWAIT 3'h6
`define RAQ_ST_RAMP 3'h7
`define RAQ_EDM_AUTO 2'h0
`define RAQ_EDM_SINGLE 2'h1
`define RAQ_EDM_CONT 2'h2
`define RAQ_CHPM_IQ 3'h1
`define RAQ_ACK_TICK_US 16
`define RAQ_CLK_MHZ 125
`define RAQ_ACK_TICK_CYC (`RAQ_ACK_TICK_US * `RAQ_CLK_MHZ)
`define RAQ_ED_TICK_CYC (`RAQ_CLK_MHZ)
`endif

//--- logic/raq_sequencer.v
// Purpose: Radio state sequencing for auto-ack receive and I/Q radio mode
// Assumes: Baseband events are one-cycle pulses on core_clk_in; stream pins are async
// Notes: Flags are one-cycle event pulses; host side keeps its own sticky status
`timescale 1ns/1ps
`include "raq_defines.vh"
module raq_sequencer #(
   parameter ACK_TICK_CYC = `RAQ_ACK_TICK_CYC,
   parameter ED_TICK_CYC = `RAQ_ED_TICK_CYC,
   parameter RAMP_CYC = 32,
   parameter LEN_W = 11,
   parameter IQ_ONLY = 0
)(
   input wire core_clk_in,
   input wire rst_n_in,
   input wire cmd_write_in,
   input wire [2:0] cmd_value_in,
   input wire chip_mode_write_in,
   input wire [2:0] chip_mode_field_in,
   input wire embedded_tx_control_in,
   input wire ed_mode_write_in,
   input wire [1:0] measurement_mode_field_in,
   input wire [7:0] energy_duration_in,
   input wire gain_freeze_bit_in,
   input wire auto_acknowledge_in,
   input wire [7:0] ack_delay_low_in,
   input wire [7:0] ack_delay_high_in,
   input wire preamble_det_in,
   input wire header_ok_in,
   input wire addr_match_in,
   input wire ack_needed_in,
   input wire frame_end_in,
   input wire fcs_ok_in,
   input wire frame_abort_in,
   input wire [LEN_W-1:0] frame_len_in,
   input wire [7:0] rssi_in,
   input wire ack_tx_done_in,
   input wire serial_tx_clock_in,
   input wire i_data_flag_in,
   output reg [2:0] state_out,
   output reg iq_mode_out,
   output reg agc_hold_out,
   output reg rx_frame_start_irq_out,
   output reg rx_address_match_irq_out,
   output reg rx_frame_end_irq_out,
   output reg tx_frame_end_irq_out,
   output reg transceiver_ready_irq_out,
   output reg energy_done_irq_out,
   output reg ack_tx_start_out,
   output reg [LEN_W-1:0] rx_length_low_high_out,
   output reg [10:0] rx_buffer_start_out,
   output reg [7:0] energy_value_out,
   output reg tx_serial_en_out,
   output reg iq_rx_stream_out,
   output reg pa_on_out,
   output reg serial_tx_clock_edge_out
);
   reg [2:0] state_reg;
   reg [2:0] flag_sync_reg;
   reg [2:0] clk_sync_reg;
   reg [23:0] ack_cnt_reg;
   reg [15:0] ack_ticks_reg;
   reg [15:0] ramp_cnt_reg;
   reg [7:0] ed_ticks_reg;
   reg [15:0] ed_cnt_reg;
   reg ed_busy_reg;
   reg ed_cont_reg;
   reg ed_notify_reg;
   reg [7:0] ed_max_reg;
   reg frz_d_reg;
   reg ack_pending_reg;
   reg strobe_flag_reg;
   reg clk_lvl_reg;
   wire flag_hi;
   wire flag_rise;
   wire flag_fall;
   wire iq_mode;
   wire spi_ok;
   wire ack_tick;
   wire ed_tick;
   wire prep_cmd;

   // Change counted only when the two later stages agree
   assign flag_hi = flag_sync_reg[1] & flag_sync_reg[2];
   assign flag_rise = flag_sync_reg[1] & flag_sync_reg[2] & ~strobe_flag_reg;
   assign flag_fall = ~flag_sync_reg[1] & ~flag_sync_reg[2] & strobe_flag_reg;
   assign iq_mode = iq_mode_out;
   // Embedded control locks out SPI transmit commands in I/Q mode
   assign spi_ok = ~(iq_mode & embedded_tx_control_in);
   assign prep_cmd = cmd_write_in & (cmd_value_in == `RAQ_CMD_TRANSMIT_PREPARE_STATE) & spi_ok;
   assign ack_tick = (ack_cnt_reg[15:0] == ACK_TICK_CYC[15:0] - 16'h0001);
   assign ed_tick = (ed_cnt_reg == ED_TICK_CYC[15:0] - 16'h0001);

   always @(posedge core_clk_in)
   begin
      if (!rst_n_in)
      begin
         flag_sync_reg <= 3'h0;
         clk_sync_reg <= 3'h0;
         strobe_flag_reg <= 1'b0;
         clk_lvl_reg <= 1'b0;
         serial_tx_clock_edge_out <= 1'b0;
      end
      else
      begin
         flag_sync_reg <= {flag_sync_reg[1:0], i_data_flag_in};
         clk_sync_reg <= {clk_sync_reg[1:0], serial_tx_clock_in};
         if (flag_sync_reg[1] == flag_sync_reg[2])
            strobe_flag_reg <= flag_sync_reg[2];
         if (clk_sync_reg[1] == clk_sync_reg[2])
            clk_lvl_reg <= clk_sync_reg[2];
         // One pulse per rising link edge, not a toggle while high
         serial_tx_clock_edge_out <= clk_sync_reg[1] & clk_sync_reg[2] & ~clk_lvl_reg
            & tx_serial_en_out;
      end
   end

   always @(posedge core_clk_in)
   begin
      if (!rst_n_in)
      begin
         state_reg <= `RAQ_ST_OFF;
         iq_mode_out <= 1'b0;
         agc_hold_out <= 1'b0;
         rx_frame_start_irq_out <= 1'b0;
         rx_address_match_irq_out <= 1'b0;
         rx_frame_end_irq_out <= 1'b0;
         tx_frame_end_irq_out <= 1'b0;
         transceiver_ready_irq_out <= 1'b0;
         ack_tx_start_out <= 1'b0;
         rx_length_low_high_out <= {LEN_W{1'b0}};
         rx_buffer_start_out <= 11'h000;
         ack_pending_reg <= 1'b0;
         ack_cnt_reg <= 24'h000000;
         ack_ticks_reg <= 16'h0000;
         ramp_cnt_reg <= 16'h0000;
         tx_serial_en_out <= 1'b0;
         iq_rx_stream_out <= 1'b0;
         pa_on_out <= 1'b0;
         state_out <= `RAQ_ST_OFF;
      end
      else
      begin
         rx_frame_start_irq_out <= 1'b0;
         rx_address_match_irq_out <= 1'b0;
         rx_frame_end_irq_out <= 1'b0;
         tx_frame_end_irq_out <= 1'b0;
         transceiver_ready_irq_out <= 1'b0;
         ack_tx_start_out <= 1'b0;
         // Variant strap is a parameter so no port is caught under reset
         if (IQ_ONLY != 0)
            iq_mode_out <= 1'b1;
         else if (chip_mode_write_in)
            iq_mode_out <= (chip_mode_field_in == `RAQ_CHPM_IQ);
         case (state_reg)
            `RAQ_ST_OFF:
            begin
               if (prep_cmd)
               begin
                  state_reg <= `RAQ_ST_PREP;
                  transceiver_ready_irq_out <= 1'b1;
                  tx_serial_en_out <= iq_mode;
               end
            end
            `RAQ_ST_PREP:
            begin
               if (cmd_write_in && cmd_value_in == `RAQ_CMD_RX)
               begin
                  state_reg <= `RAQ_ST_RX;
                  iq_rx_stream_out <= iq_mode;
               end
               else if (cmd_write_in && cmd_value_in == `RAQ_CMD_TX && spi_ok)
               begin
                  state_reg <= `RAQ_ST_TX;
                  pa_on_out <= 1'b1;
               end
               else if (iq_mode && !spi_ok && flag_rise)
               begin
                  state_reg <= `RAQ_ST_TX;
                  pa_on_out <= 1'b1;
               end
               else if (cmd_write_in && cmd_value_in == `RAQ_CMD_OFF)
               begin
                  state_reg <= `RAQ_ST_OFF;
                  tx_serial_en_out <= 1'b0;
               end
            end
            `RAQ_ST_RX:
            begin
               if (prep_cmd)
               begin
                  state_reg <= `RAQ_ST_PREP;
                  transceiver_ready_irq_out <= 1'b1;
                  tx_serial_en_out <= iq_mode;
                  iq_rx_stream_out <= 1'b0;
                  agc_hold_out <= 1'b0;
               end
               else if (!iq_mode)
               begin
                  if (header_ok_in)
                     rx_frame_start_irq_out <= 1'b1;
                  if (addr_match_in)
                     rx_address_match_irq_out <= 1'b1;
                  if (addr_match_in && ack_needed_in && auto_acknowledge_in)
                     ack_pending_reg <= 1'b1;
                  if (frame_end_in && fcs_ok_in)
                  begin
                     rx_frame_end_irq_out <= 1'b1;
                     rx_length_low_high_out <= frame_len_in;
                     rx_buffer_start_out <= 11'h000;
                     agc_hold_out <= 1'b0;
                     ack_cnt_reg <= 24'h000000;
                     ack_ticks_reg <= {ack_delay_high_in, ack_delay_low_in};
                     if (ack_pending_reg)
                        state_reg <= `RAQ_ST_ACKWAIT;
                     else
                     begin
                        state_reg <= `RAQ_ST_PREP;
                        transceiver_ready_irq_out <= 1'b1;
                     end
                     ack_pending_reg <= 1'b0;
                  end
                  else if (frame_abort_in || (frame_end_in && !fcs_ok_in))
                  begin
                     agc_hold_out <= 1'b0;
                     ack_pending_reg <= 1'b0;
                  end
                  // New preamble wins over a release in the same cycle
                  if (preamble_det_in)
                     agc_hold_out <= 1'b1;
               end
            end
            `RAQ_ST_ACKWAIT:
            begin
               // Delay counted in ticks so the 16-bit value spans long waits
               if (ack_ticks_reg == 16'h0000)
               begin
                  state_reg <= `RAQ_ST_TX;
                  ack_tx_start_out <= 1'b1;
                  pa_on_out <= 1'b1;
               end
               else if (ack_tick)
               begin
                  ack_cnt_reg <= 24'h000000;
                  ack_ticks_reg <= ack_ticks_reg - 16'h0001;
               end
               else
                  ack_cnt_reg <= ack_cnt_reg + 24'h000001;
            end
            `RAQ_ST_TX:
            begin
               if (!iq_mode && ack_tx_done_in)
               begin
                  state_reg <= `RAQ_ST_PREP;
                  tx_frame_end_irq_out <= 1'b1;
                  transceiver_ready_irq_out <= 1'b1;
                  pa_on_out <= 1'b0;
               end
               else if (prep_cmd || (iq_mode && !spi_ok && flag_fall))
               begin
                  state_reg <= `RAQ_ST_RAMP;
                  ramp_cnt_reg <= 16'h0000;
               end
            end
            `RAQ_ST_RAMP:
            begin
               if (ramp_cnt_reg == RAMP_CYC[15:0] - 16'h0001)
               begin
                  state_reg <= `RAQ_ST_PREP;
                  transceiver_ready_irq_out <= 1'b1;
                  tx_serial_en_out <= iq_mode;
                  pa_on_out <= 1'b0;
               end
               else
                  ramp_cnt_reg <= ramp_cnt_reg + 16'h0001;
            end
            default:
               state_reg <= `RAQ_ST_OFF;
         endcase
         state_out <= state_reg;
      end
   end

   // Energy measurement: peak rssi over the programmed duration in ticks
   always @(posedge core_clk_in)
   begin
      if (!rst_n_in)
      begin
         ed_busy_reg <= 1'b0;
         ed_cont_reg <= 1'b0;
         ed_notify_reg <= 1'b0;
         ed_cnt_reg <= 16'h0000;
         ed_ticks_reg <= 8'h00;
         ed_max_reg <= 8'h00;
         frz_d_reg <= 1'b0;
         energy_value_out <= 8'h00;
         energy_done_irq_out <= 1'b0;
      end
      else
      begin
         frz_d_reg <= gain_freeze_bit_in;
         energy_done_irq_out <= 1'b0;
         if (header_ok_in && state_reg == `RAQ_ST_RX && !iq_mode)
         begin
            ed_busy_reg <= 1'b1;
            ed_notify_reg <= 1'b0;
            ed_cont_reg <= 1'b0;
            ed_cnt_reg <= 16'h0000;
            ed_ticks_reg <= energy_duration_in;
            ed_max_reg <= 8'h00;
         end
         else if (ed_mode_write_in && measurement_mode_field_in != `RAQ_EDM_AUTO)
         begin
            ed_busy_reg <= 1'b1;
            ed_notify_reg <= 1'b1;
            ed_cont_reg <= (measurement_mode_field_in == `RAQ_EDM_CONT);
            ed_cnt_reg <= 16'h0000;
            ed_ticks_reg <= energy_duration_in;
            ed_max_reg <= 8'h00;
         end
         else if (gain_freeze_bit_in && !frz_d_reg)
         begin
            ed_busy_reg <= 1'b1;
            ed_notify_reg <= 1'b0;
            ed_cont_reg <= 1'b0;
            ed_cnt_reg <= 16'h0000;
            ed_ticks_reg <= energy_duration_in;
            ed_max_reg <= 8'h00;
         end
         else if (ed_busy_reg)
         begin
            if (rssi_in > ed_max_reg)
               ed_max_reg <= rssi_in;
            if (ed_tick)
            begin
               ed_cnt_reg <= 16'h0000;
               if (ed_ticks_reg <= 8'h01)
               begin
                  energy_value_out <= (rssi_in > ed_max_reg) ? rssi_in : ed_max_reg;
                  energy_done_irq_out <= ed_notify_reg;
                  ed_busy_reg <= ed_cont_reg;
                  ed_ticks_reg <= energy_duration_in;
                  ed_max_reg <= 8'h00;
               end
               else
                  ed_ticks_reg <= ed_ticks_reg - 8'h01;
            end
            else
               ed_cnt_reg <= ed_cnt_reg + 16'h0001;
         end
      end
   end
endmodule // raq_sequencer

//--- tb/raq_sequencer_monitor.sv
// Purpose: Temporal checks on the sequencer ports
// Assumes: Registered outputs, one-cycle event pulses
// Notes: Attached to every sequencer instance by bind
`timescale 1ns/1ps
module raq_sequencer_monitor #(
   parameter LEN_W = 11
)(
   input wire core_clk_in,
   input wire rst_n_in,
   input wire cmd_write_in,
   input wire [2:0] cmd_value_in,
   input wire embedded_tx_control_in,
   input wire preamble_det_in,
   input wire header_ok_in,
   input wire addr_match_in,
   input wire frame_end_in,
   input wire fcs_ok_in,
   input wire frame_abort_in,
   input wire [LEN_W-1:0] frame_len_in,
   input wire ack_tx_done_in,
   input wire [2:0] state_out,
   input wire iq_mode_out,
   input wire agc_hold_out,
   input wire rx_frame_start_irq_out,
   input wire rx_address_match_irq_out,
   input wire rx_frame_end_irq_out,
   input wire tx_frame_end_irq_out,
   input wire transceiver_ready_irq_out,
   input wire ack_tx_start_out,
   input wire [LEN_W-1:0] rx_length_low_high_out
);
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (!rst_n_in);
   property p_hold;
      state_out == 3'h5 && !iq_mode_out && preamble_det_in && !cmd_write_in |=> agc_hold_out;
   endproperty
   a_hold: assert property (p_hold) else $error("gain not held");
   property p_fs;
      rx_frame_start_irq_out |-> $past(header_ok_in);
   endproperty
   a_fs: assert property (p_fs) else $error("stray frame start");
   property p_am;
      rx_address_match_irq_out |-> $past(addr_match_in);
   endproperty
   a_am: assert property (p_am) else $error("stray address match");
   property p_fe;
      rx_frame_end_irq_out |-> $past(frame_end_in && fcs_ok_in);
   endproperty
   a_fe: assert property (p_fe) else $error("frame end without good check");
   property p_len;
      rx_frame_end_irq_out |-> rx_length_low_high_out == $past(frame_len_in);
   endproperty
   a_len: assert property (p_len) else $error("length not presented");
   property p_bad;
      state_out == 3'h5 && !iq_mode_out && frame_abort_in && !cmd_write_in
         |=> !agc_hold_out ##1 state_out == 3'h5;
   endproperty
   a_bad: assert property (p_bad) else $error("abort mishandled");
   property p_ack;
      ack_tx_start_out |-> $past(state_out) == 3'h6;
   endproperty
   a_ack: assert property (p_ack) else $error("ack without wait");
   property p_tx_frame_end_irq;
      tx_frame_end_irq_out |-> $past(ack_tx_done_in) ##1 state_out == 3'h3;
   endproperty
   a_tx_frame_end_irq: assert property (p_tx_frame_end_irq) else $error("ack end mishandled");
   property p_rdy;
      cmd_write_in && cmd_value_in == 3'h3 && state_out == 3'h5 && !$past(cmd_write_in)
         && !(iq_mode_out && embedded_tx_control_in) |=> transceiver_ready_irq_out;
   endproperty
   a_rdy: assert property (p_rdy) else $error("no ready leaving receive");
   property p_ign;
      iq_mode_out && embedded_tx_control_in && cmd_write_in && cmd_value_in == 3'h4
         && state_out == 3'h3 |=> ##1 state_out == 3'h3;
   endproperty
   a_ign: assert property (p_ign) else $error("command not ignored");
endmodule // raq_sequencer_monitor
bind raq_sequencer raq_sequencer_monitor #(.LEN_W(LEN_W)) raq_sequencer_monitor_inst (.*);

//--- tb/raq_baseband_model.sv
// Purpose: Baseband side of the serial I/Q transmit stream
// Assumes: Link clock runs only while a burst is sent
// Notes: Flag moves on the falling link edge, away from sampling
`timescale 1ns/1ps
module raq_baseband_model (
   input wire send_in,
   output reg serial_tx_clock_out,
   output reg i_data_flag_out
);
   task tick;
      begin
         #62.5 serial_tx_clock_out = 1'b1;
         #62.5 serial_tx_clock_out = 1'b0;
      end
   endtask
   initial
   begin
      serial_tx_clock_out = 1'b0;
      i_data_flag_out = 1'b0;
      forever
      begin
         @(posedge send_in);
         repeat (4) tick;
         i_data_flag_out = 1'b1;
         repeat (8) tick;
         i_data_flag_out = 1'b0;
         repeat (4) tick;
      end
   end
endmodule // raq_baseband_model

//--- tb/raq_sequencer_bench.sv
// Purpose: Self-checking bench for the radio state sequencer
// Assumes: Events and commands driven at the falling edge
// Notes: Short tick parameters keep ack and ramp waits brief
`timescale 1ns/1ps
`include "raq_defines.vh"
module raq_sequencer_bench;
   reg core_clk_in = 1'b0;
   reg rst_n_in = 1'b0;
   reg [15:0] p = 16'h0000;
   reg [2:0] cmd_v = 3'h0;
   reg [2:0] chpm = 3'h0;
   reg [1:0] edm = 2'h0;
   reg [7:0] dly_l = 8'h01;
   reg [10:0] flen = 11'h000;
   reg [7:0] rssi = 8'h00;
   reg eec = 1'b0, frz = 1'b0, need = 1'b0, fcs = 1'b0, send = 1'b0;
   reg auto_acknowledge = 1'b1;
   reg [7:0] dly_h = 8'h00, edd = 8'h01;
   integer n_sclk = 0;
   wire sedge;
   reg [31:0] lfsr = 32'h4f58f2ec;
   integer mismatches = 0;
   integer n_checks = 0;
   integer cyc = 0;
   integer n, k, e;
   wire sclk, iflag;
   wire [2:0] st;
   wire [7:0] edv;
   wire [10:0] rlen, rbuf;
   wire [12:0] ev;
   assign ev[12] = 1'b1;
   raq_baseband_model raq_baseband_model_inst (.send_in(send),
      .serial_tx_clock_out(sclk), .i_data_flag_out(iflag));
   raq_sequencer #(.ACK_TICK_CYC(4), .ED_TICK_CYC(2), .RAMP_CYC(4)) raq_sequencer_inst (
      .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .cmd_write_in(p[0]),
      .cmd_value_in(cmd_v), .chip_mode_write_in(p[1]), .chip_mode_field_in(chpm),
      .embedded_tx_control_in(eec), .ed_mode_write_in(p[2]),
      .measurement_mode_field_in(edm), .energy_duration_in(edd),
      .gain_freeze_bit_in(frz), .auto_acknowledge_in(auto_acknowledge), .ack_delay_low_in(dly_l),
      .ack_delay_high_in(dly_h), .preamble_det_in(p[3]), .header_ok_in(p[4]),
      .addr_match_in(p[5]), .ack_needed_in(need), .frame_end_in(p[6]), .fcs_ok_in(fcs),
      .frame_abort_in(p[7]), .frame_len_in(flen), .rssi_in(rssi), .ack_tx_done_in(p[8]),
      .serial_tx_clock_in(sclk), .i_data_flag_in(iflag), .state_out(st),
      .iq_mode_out(ev[0]), .agc_hold_out(ev[1]), .rx_frame_start_irq_out(ev[2]),
      .rx_address_match_irq_out(ev[3]), .rx_frame_end_irq_out(ev[4]),
      .transceiver_ready_irq_out(ev[5]), .tx_frame_end_irq_out(ev[6]),
      .energy_done_irq_out(ev[7]), .ack_tx_start_out(ev[8]), .rx_length_low_high_out(rlen),
      .rx_buffer_start_out(rbuf), .energy_value_out(edv), .tx_serial_en_out(ev[9]),
      .iq_rx_stream_out(ev[10]), .pa_on_out(ev[11]), .serial_tx_clock_edge_out(sedge));
   function [31:0] nxt(input [31:0] v);
      nxt = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   function integer ack_cyc(input [7:0] h, input [7:0] l);
      ack_cyc = {h, l} * 4;
   endfunction
   task chk(input [15:0] got, input [15:0] exp);
      begin
         n_checks = n_checks + 1;
         if (got !== exp)
         begin
            mismatches = mismatches + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   // Pulse one input, then watch one output on every falling edge
   task go(input integer pi, input integer eo, output integer cnt);
      begin
         cnt = 0;
         p[pi] = 1'b1;
         @(negedge core_clk_in);
         p = 16'h0000;
         while (ev[eo] !== 1'b1 && cnt < 400)
         begin
            @(negedge core_clk_in);
            cnt = cnt + 1;
         end
         chk(cnt < 400, 1'b1);
      end
   endtask
   task cmd(input [2:0] v, input integer eo);
      begin
         cmd_v = v;
         go(0, eo, n);
      end
   endtask
   task idle(input integer c);
      repeat (c) @(negedge core_clk_in);
   endtask
   task report_and_stop;
      begin
         $display("checks=%0d mismatches=%0d", n_checks, mismatches);
         if (mismatches == 0 && n_checks > 0)
            $display("DONE - PASS");
         else
            $display("DONE - FAIL");
         $finish;
      end
   endtask
   always #4 core_clk_in = ~core_clk_in;
   // Link edge pulses stand a full cycle, so each is seen once here
   always @(negedge core_clk_in)
      if (sedge === 1'b1)
         n_sclk = n_sclk + 1;
   always @(posedge core_clk_in)
   begin
      cyc = cyc + 1;
      if (cyc == 20000)
      begin
         mismatches = mismatches + 1;
         report_and_stop;
      end
   end
   initial
   begin
      idle(4);
      rst_n_in = 1'b1;
      idle(1);
      chk(st, `RAQ_ST_OFF);
      cmd(`RAQ_CMD_TRANSMIT_PREPARE_STATE, 5);
      idle(1);
      chk(st, `RAQ_ST_PREP);
      lfsr = nxt(lfsr);
      dly_l = {6'h00, lfsr[1:0] | 2'h1};
      cmd(`RAQ_CMD_RX, 12);
      idle(2);
      chk(st, `RAQ_ST_RX);
      // Abort, bad check, then a good frame with ack
      for (k = 0; k < 3; k = k + 1)
      begin
         lfsr = nxt(lfsr);
         flen = lfsr[10:0];
         rssi = lfsr[18:11];
         go(3, 1, n);
         go(4, 2, n);
         need = 1'b1;
         go(5, 3, n);
         fcs = k[1];
         if (k < 2)
         begin
            go(k == 0 ? 7 : 6, 12, n);
            idle(2);
            chk(ev[1], 1'b0);
            chk(st, `RAQ_ST_RX);
         end
      end
      go(6, 4, n);
      chk(rlen, flen);
      chk(rbuf, 11'h000);
      chk(edv, rssi);
      e = ack_cyc(dly_h, dly_l);
      go(15, 8, n);
      chk(n >= e - 2 && n <= e + 3, 1'b1);
      go(8, 6, n);
      idle(1);
      chk(st, `RAQ_ST_PREP);
      cmd(`RAQ_CMD_TX, 12);
      idle(2);
      chk(st, `RAQ_ST_TX);
      cmd(`RAQ_CMD_TRANSMIT_PREPARE_STATE, 5);
      cmd(`RAQ_CMD_RX, 12);
      lfsr = nxt(lfsr);
      rssi = lfsr[7:0];
      edm = `RAQ_EDM_SINGLE;
      go(2, 7, n);
      chk(edv, rssi);
      lfsr = nxt(lfsr);
      rssi = lfsr[7:0] | 8'h01;
      edm = `RAQ_EDM_AUTO;
      go(2, 12, n);
      frz = 1'b1;
      idle(8);
      chk(edv, rssi);
      frz = 1'b0;
      cmd(`RAQ_CMD_TRANSMIT_PREPARE_STATE, 5);
      chpm = `RAQ_CHPM_IQ;
      go(1, 0, n);
      cmd(`RAQ_CMD_RX, 10);
      frz = 1'b1;
      idle(4);
      frz = 1'b0;
      cmd(`RAQ_CMD_TRANSMIT_PREPARE_STATE, 5);
      idle(1);
      chk(ev[9], 1'b1);
      eec = 1'b1;
      cmd(`RAQ_CMD_TX, 12);
      idle(3);
      chk(st, `RAQ_ST_PREP);
      send = 1'b1;
      go(15, 11, n);
      idle(1);
      chk(st, `RAQ_ST_TX);
      go(15, 5, n);
      chk(ev[11], 1'b0);
      // Let the trailing padding ticks of the burst pass
      idle(80);
      chk(n_sclk[15:0], 16'h0010);
      report_and_stop;
   end
endmodule // raq_sequencer_bench
